// >>> hdl/sarr_pkg.sv
// ----------------------------------------------------------------------
// Shared constants and types of the result readout
// ----------------------------------------------------------------------
package sarr_pkg;

  // Result word
  localparam int RES_W = 16;
  localparam int HALF_W = 8;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // Timing, in nanoseconds and in system clock cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 1500;
  localparam int ACQ_TIME_NS = 500;
  localparam int MSCLK_HALF_NS = 25;
  // Least times round up to whole cycles
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MSCLK_HALF_CYC = (MSCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bit counter of the serial link
  localparam int BIT_CNT_W = 5;
  localparam logic [4:0] BIT_FIRST = 5'h00;
  localparam logic [4:0] BIT_LAST = 5'h0f;
  localparam logic [4:0] BIT_ALL = 5'h10;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    SARR_IDLE = 2'b00,
    SARR_CONV = 2'b01,
    SARR_MREAD = 2'b10
  } sarr_conv_t;

  // Pins and link events that enter the system clock domain
  typedef struct packed {
    logic ser_sel;
    logic lane_swap;
    logic clk_src;
    logic clk_inv;
    logic rd_mode;
    logic cnv_n;
    logic pwr_dn;
    logic sel_n;
    logic start_tgl;
    logic done_tgl;
  } sarr_pins_t;

  localparam sarr_pins_t PINS_RST = '{
    ser_sel: 1'b0, lane_swap: 1'b0, clk_src: 1'b0, clk_inv: 1'b0, rd_mode: 1'b0,
    cnv_n: 1'b1, pwr_dn: 1'b0, sel_n: 1'b1, start_tgl: 1'b0, done_tgl: 1'b0
  };

endpackage

// >>> hdl/sarr_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Three-stage input synchroniser with agreement filter
// ----------------------------------------------------------------------
module sarr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous levels in, filtered levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_sync;

  // A bit moves only when stages two and three agree; stage one feeds stage two only
  always_comb begin
    next_sync = ((~(s2 ^ s3)) & s3) | ((s2 ^ s3) & o_sync);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta <= i_async;
      s2 <= meta;
      s3 <= s2;
      o_sync <= next_sync;
    end
  end

endmodule

// >>> hdl/sarr_link.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Slave serial shifter, clocked by the host's serial clock
// ----------------------------------------------------------------------
module sarr_link (
  // Link clock and system reset
  input wire logic i_sclk_link,
  input wire logic i_rst,
  // Link pins
  input wire logic i_sel_n,
  input wire logic i_chain_in,
  // Held result word, stable outside conversion end
  input wire logic [15:0] i_word,
  // Serial bit and events towards the system domain
  output logic o_bit,
  output logic o_start_tgl,
  output logic o_done_tgl
);

  logic rst_meta;
  logic rst_l;
  logic chain_q;
  logic loaded;
  logic [sarr_pkg::BIT_CNT_W-1:0] cnt;
  logic [15:0] shreg;
  logic next_loaded;
  logic [sarr_pkg::BIT_CNT_W-1:0] next_cnt;
  logic [15:0] next_shreg;
  logic next_start_tgl;
  logic next_done_tgl;

  // Reset brought onto the link clock; needs a few edges to take hold
  always_ff @(posedge i_sclk_link) begin
    rst_meta <= i_rst;
    rst_l <= rst_meta;
  end

  // Chain input is taken on the rising edge, opposite to the shift edge
  always_ff @(posedge i_sclk_link) begin
    chain_q <= i_chain_in; // [R18] [R17]
  end

  // Shift only while chip select and read are both low
  always_comb begin
    next_loaded = loaded;
    next_cnt = cnt;
    next_shreg = shreg;
    next_start_tgl = o_start_tgl;
    next_done_tgl = o_done_tgl;
    if (rst_l) begin
      next_loaded = 1'b0;
      next_cnt = sarr_pkg::BIT_FIRST;
      next_start_tgl = 1'b0;
      next_done_tgl = 1'b0;
    end else if (i_sel_n) begin
      next_loaded = 1'b0; // [R13]
      next_cnt = sarr_pkg::BIT_FIRST;
    end else begin
      next_loaded = 1'b1;
      // Past bit 16 the chained upstream bits keep following
      next_shreg = {(loaded ? shreg[14:0] : i_word[14:0]), chain_q}; // [R5] [R18]
      if (cnt != sarr_pkg::BIT_ALL) begin
        next_cnt = cnt + 5'h01;
      end
      if (cnt == sarr_pkg::BIT_FIRST) begin
        next_start_tgl = ~o_start_tgl;
      end
      if (cnt == sarr_pkg::BIT_LAST) begin
        next_done_tgl = ~o_done_tgl;
      end
    end
  end

  // Deselect clears the frame position at once; a gated clock gives no edge to do it
  always_ff @(negedge i_sclk_link or posedge i_sel_n) begin
    if (i_sel_n) begin
      loaded <= 1'b0; // [R13]
      cnt <= sarr_pkg::BIT_FIRST;
    end else begin
      loaded <= next_loaded;
      cnt <= next_cnt;
    end
  end

  // Data moves on the falling edge so it stands across both edges
  always_ff @(negedge i_sclk_link) begin
    shreg <= next_shreg; // [R6] [R14]
    o_start_tgl <= next_start_tgl;
    o_done_tgl <= next_done_tgl;
  end

  // First bit is shown before any edge, which a gated clock needs
  assign o_bit = loaded ? shreg[15] : i_word[15]; // [R5] [R14]

endmodule

// >>> hdl/sarr_readout.sv
`timescale 1ns/1ps
// What this block does
// [R1] Serial/parallel select low puts results on the parallel data bus.
// [R2] Host reads parallel after conversion, or early in the next conversion.
// [R3] Lane exchange low: low byte on D[7:0], high byte on D[15:8].
// [R4] Lane exchange high: low byte on D[15:8], high byte on D[7:0].
// [R5] Serial select high shifts 16 bits out, most significant first.
// [R6] Each serial bit stands across both edges of the serial clock.
// [R7] Clock source select low: the block makes and drives the serial clock.
// [R8] Master mode also drives a frame-valid strobe marking valid bits.
// [R9] Master serial clock and frame-valid strobe can be inverted together.
// [R10] Master mode: read-mode input picks read after or during conversion.
// [R11] Master read-after-conversion: busy falls only after all 16 bits.
// [R12] Clock source select high: serial clock comes from the host.
// [R13] Slave: clock gated by chip select; shift only with select and read low.
// [R14] Slave accepts continuous or gated clock, idling high or low.
// [R15] Host keeps its clock still in the late half of busy.
// [R16] Slave read after conversion once busy falls, clock up to 40 MHz.
// [R17] Only slave read-after-conversion uses read-mode input as chain input; the link shifts it in on every slave read.
// [R18] Chain input is latched on the edge opposite the shift edge.
// [R19] Slave read during conversion: unfinished 16-bit read pulses overrun flag.
// [R20] Host holds the read-mode input fixed in slave read-during-conversion.
// [R21] Host uses a gated clock of at least 18 MHz for that mode.
// [R22] Chip select or read high puts all interface outputs in high impedance.
// [R23] A started conversion always runs to its end, even on power-down.
// [R24] Last result is held until the next conversion completes.
module sarr_readout #(
  parameter int CONV_CYC = sarr_pkg::CONV_CYC,
  parameter int ACQ_CYC = sarr_pkg::ACQ_CYC,
  parameter int MSCLK_HALF_CYC = sarr_pkg::MSCLK_HALF_CYC
) (
  // Clocks and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_sclk_link,
  // Conversion core
  input wire logic [15:0] i_conv_result,
  input wire logic i_convert_start_n,
  input wire logic i_power_down,
  output logic o_busy,
  // Mode pins
  input wire logic i_serial_parallel_select,
  input wire logic i_byte_lane_exchange,
  input wire logic i_clock_source_select,
  input wire logic i_clock_invert,
  input wire logic i_read_mode_chain_input,
  // Bus select pins
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  // Parallel data bus
  output logic [15:0] o_data,
  output logic o_data_oe_n,
  // Serial link
  output logic o_serial_result_out,
  output logic o_serial_oe_n,
  output logic o_sclk_out,
  output logic o_sclk_oe_n,
  output logic o_frame_valid,
  output logic o_frame_valid_oe_n,
  output logic o_read_overrun_flag
);

  localparam int CNT_W = $clog2(CONV_CYC + ACQ_CYC + 1);
  localparam int PH_W = $clog2(MSCLK_HALF_CYC + 1);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic sel_n_raw;
  logic link_bit;
  logic link_start_tgl;
  logic link_done_tgl;
  sarr_pkg::sarr_pins_t pin_raw;
  sarr_pkg::sarr_pins_t pin;

  // Chip select and read act alike, so they are merged first
  assign sel_n_raw = i_cs_n | i_rd_n; // [R22]

  always_comb begin
    pin_raw.ser_sel = i_serial_parallel_select;
    pin_raw.lane_swap = i_byte_lane_exchange;
    pin_raw.clk_src = i_clock_source_select;
    pin_raw.clk_inv = i_clock_invert;
    pin_raw.rd_mode = i_read_mode_chain_input;
    pin_raw.cnv_n = i_convert_start_n;
    pin_raw.pwr_dn = i_power_down;
    pin_raw.sel_n = sel_n_raw;
    pin_raw.start_tgl = link_start_tgl;
    pin_raw.done_tgl = link_done_tgl;
  end

  sarr_sync #(
    .W($bits(sarr_pkg::sarr_pins_t)),
    .RST_VAL(sarr_pkg::PINS_RST)
  ) u_sync (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_async(pin_raw),
    .o_sync(pin)
  );

  // ----------------------------------------------------------------------
  // Slave serial link on the host clock
  // ----------------------------------------------------------------------
  logic [15:0] result;

  // The held result is quasi-static: it only changes at conversion end,
  // when the host is to keep its clock still
  sarr_link u_link (
    .i_sclk_link(i_sclk_link),
    .i_rst(i_rst),
    .i_sel_n(sel_n_raw),
    .i_chain_in(i_read_mode_chain_input),
    .i_word(result),
    .o_bit(link_bit),
    .o_start_tgl(link_start_tgl),
    .o_done_tgl(link_done_tgl)
  ); // [R12] [R15] [R16]

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  sarr_pkg::sarr_conv_t st;
  sarr_pkg::sarr_conv_t next_st;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [15:0] next_result;
  logic cnv_prev;
  logic conv_start;
  logic conv_end;
  logic master;
  logic m_act;
  logic m_done;
  logic m_start;

  assign master = pin.ser_sel & ~pin.clk_src; // [R7]

  // Start on a falling edge, or on a level held low once acquisition has run
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_result = result;
    conv_start = 1'b0;
    conv_end = 1'b0;
    unique case (st)
      sarr_pkg::SARR_IDLE: begin
        if (cnt != CNT_W'(ACQ_CYC)) begin
          next_cnt = cnt + CNT_W'(1);
        end
        if (!pin.cnv_n && !pin.pwr_dn && (cnv_prev || cnt == CNT_W'(ACQ_CYC))) begin
          conv_start = 1'b1;
          next_st = sarr_pkg::SARR_CONV;
          next_cnt = '0;
        end
      end
      sarr_pkg::SARR_CONV: begin
        // Neither the start pin nor power-down can cut this short
        next_cnt = cnt + CNT_W'(1); // [R23]
        if (cnt == CNT_W'(CONV_CYC - 1)) begin
          conv_end = 1'b1;
          next_result = i_conv_result; // [R24]
          next_cnt = '0;
          if (master && !pin.rd_mode) begin
            next_st = sarr_pkg::SARR_MREAD; // [R10] [R11]
          end else begin
            next_st = sarr_pkg::SARR_IDLE;
          end
        end
      end
      sarr_pkg::SARR_MREAD: begin
        // Busy stays high until the last master bit has gone
        if (m_done) begin
          next_st = sarr_pkg::SARR_IDLE; // [R11]
        end
      end
      default: begin
        next_st = sarr_pkg::SARR_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st <= sarr_pkg::SARR_IDLE;
      cnt <= '0;
      result <= sarr_pkg::RESULT_RST;
      cnv_prev <= 1'b1;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      result <= next_result;
      cnv_prev <= pin.cnv_n;
    end
  end

  // ----------------------------------------------------------------------
  // Master serial shifter
  // ----------------------------------------------------------------------
  logic [PH_W-1:0] m_ph;
  logic [PH_W-1:0] next_m_ph;
  logic [sarr_pkg::BIT_CNT_W-1:0] m_bit;
  logic [sarr_pkg::BIT_CNT_W-1:0] next_m_bit;
  logic [15:0] m_sh;
  logic [15:0] next_m_sh;
  logic m_sclk;
  logic next_m_sclk;
  logic next_m_act;
  logic m_fv;
  logic next_m_fv;

  // During-conversion mode sends the old word at start, after-mode the new at end
  assign m_start = master && ((conv_start && pin.rd_mode) || (conv_end && !pin.rd_mode)); // [R10]

  // Clock is divided down from the system clock; data moves on its falling edge
  always_comb begin
    next_m_ph = m_ph;
    next_m_bit = m_bit;
    next_m_sh = m_sh;
    next_m_sclk = m_sclk;
    next_m_act = m_act;
    next_m_fv = m_fv;
    m_done = 1'b0;
    if (m_start) begin
      next_m_act = 1'b1;
      next_m_fv = 1'b1; // [R8]
      next_m_ph = '0;
      next_m_bit = sarr_pkg::BIT_FIRST;
      next_m_sclk = 1'b0;
      next_m_sh = (conv_end ? i_conv_result : result); // [R5]
    end else if (m_act) begin
      next_m_ph = m_ph + PH_W'(1);
      if (m_ph == PH_W'(MSCLK_HALF_CYC - 1)) begin
        next_m_ph = '0;
        next_m_sclk = ~m_sclk; // [R7]
        if (m_sclk) begin
          if (m_bit == sarr_pkg::BIT_LAST) begin
            next_m_act = 1'b0;
            next_m_fv = 1'b0;
            m_done = 1'b1;
          end else begin
            next_m_bit = m_bit + 5'h01;
            next_m_sh = {m_sh[14:0], 1'b0}; // [R6]
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      m_ph <= '0;
      m_bit <= sarr_pkg::BIT_FIRST;
      m_sh <= sarr_pkg::RESULT_RST;
      m_sclk <= 1'b0;
      m_act <= 1'b0;
      m_fv <= 1'b0;
    end else begin
      m_ph <= next_m_ph;
      m_bit <= next_m_bit;
      m_sh <= next_m_sh;
      m_sclk <= next_m_sclk;
      m_act <= next_m_act;
      m_fv <= next_m_fv;
    end
  end

  // ----------------------------------------------------------------------
  // Slave read tracking and overrun
  // ----------------------------------------------------------------------
  logic start_q;
  logic done_q;
  logic start_ev;
  logic done_ev;
  logic reading;
  logic next_reading;
  logic next_overrun;

  assign start_ev = pin.start_tgl ^ start_q;
  assign done_ev = pin.done_tgl ^ done_q;

  // A finish arriving with the conversion end still counts as finished;
  // deselecting mid-frame leaves the read unfinished, so it does not clear
  always_comb begin
    next_overrun = conv_end && pin.ser_sel && pin.clk_src && reading && !done_ev; // [R19]
    next_reading = start_ev | (reading & ~(done_ev | conv_end));
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      start_q <= 1'b0;
      done_q <= 1'b0;
      reading <= 1'b0;
      o_read_overrun_flag <= 1'b0;
    end else begin
      start_q <= pin.start_tgl;
      done_q <= pin.done_tgl;
      reading <= next_reading;
      o_read_overrun_flag <= next_overrun;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  logic [15:0] next_data;
  logic next_data_oe_n;
  logic next_ser_oe_n;
  logic next_mst_oe_n;

  // Lanes swap so an 8-bit host reads both bytes on one lane
  always_comb begin
    if (pin.lane_swap) begin
      next_data = {result[7:0], result[15:8]}; // [R4]
    end else begin
      next_data = result; // [R3] [R2]
    end
    next_data_oe_n = pin.sel_n | pin.ser_sel; // [R1] [R22]
    next_ser_oe_n = pin.sel_n | ~pin.ser_sel; // [R22]
    next_mst_oe_n = pin.sel_n | ~master; // [R7] [R12]
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_data <= sarr_pkg::RESULT_RST;
      o_data_oe_n <= 1'b1;
      o_serial_oe_n <= 1'b1;
      o_sclk_oe_n <= 1'b1;
      o_frame_valid_oe_n <= 1'b1;
      o_sclk_out <= 1'b0;
      o_frame_valid <= 1'b0;
    end else begin
      o_busy <= (next_st != sarr_pkg::SARR_IDLE); // [R11]
      o_data <= next_data;
      o_data_oe_n <= next_data_oe_n;
      o_serial_oe_n <= next_ser_oe_n;
      o_sclk_oe_n <= next_mst_oe_n;
      o_frame_valid_oe_n <= next_mst_oe_n;
      o_sclk_out <= next_m_sclk ^ pin.clk_inv; // [R9]
      o_frame_valid <= next_m_fv ^ pin.clk_inv; // [R9]
    end
  end

  // Static mode select between two registered sources, one per clock domain
  assign o_serial_result_out = pin.clk_src ? link_bit : m_sh[15]; // [R5] [R12]

endmodule

// >>> dv/sarr_readout_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port-level checks of the result readout
// ----------------------------------------------------------------------
module sarr_readout_assertions #(
  parameter int CONV_CYC = 60
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Mode and select pins
  input wire logic i_serial_parallel_select,
  input wire logic i_clock_source_select,
  input wire logic i_clock_invert,
  input wire logic i_read_mode_chain_input,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  // Outputs under watch
  input wire logic o_busy,
  input wire logic o_data_oe_n,
  input wire logic o_serial_result_out,
  input wire logic o_serial_oe_n,
  input wire logic o_sclk_out,
  input wire logic o_sclk_oe_n,
  input wire logic o_frame_valid,
  input wire logic o_frame_valid_oe_n,
  input wire logic o_read_overrun_flag
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // Polarity-corrected master clock and frame strobe
  logic sx, fx, sx_q, fx_q, m_rac;
  logic [5:0] bits;
  logic [7:0] busy_len;
  assign sx = o_sclk_out ^ i_clock_invert;
  assign fx = (o_frame_valid ^ i_clock_invert) && !o_frame_valid_oe_n;
  assign m_rac = i_serial_parallel_select && !i_clock_source_select && !i_read_mode_chain_input;
  // Clock rises per frame and busy width; saturates so a stuck busy cannot wrap
  always_ff @(posedge i_clk_sys) begin
    sx_q <= sx;
    fx_q <= fx;
    if (i_rst || (fx && !fx_q)) bits <= 6'h00;
    else if (fx && sx && !sx_q) bits <= bits + 6'h01;
    if (i_rst || !o_busy) busy_len <= 8'h00;
    else if (busy_len != 8'hff) busy_len <= busy_len + 8'h01;
  end
  a_conv_full_length: assert property (
    $fell(o_busy) && !m_rac |-> int'(busy_len) >= CONV_CYC - 1 && int'(busy_len) <= CONV_CYC)
    else $error("busy width off");
  a_hiz_when_free: assert property (
    (i_cs_n || i_rd_n) [*8] |-> o_data_oe_n && o_serial_oe_n && o_sclk_oe_n && o_frame_valid_oe_n)
    else $error("outputs driven while deselected");
  a_par_mode_only: assert property (
    !o_data_oe_n |-> !i_serial_parallel_select && o_serial_oe_n)
    else $error("parallel bus driven in serial mode");
  a_bit_holds_high: assert property (
    !o_sclk_oe_n && sx |-> $stable(o_serial_result_out))
    else $error("serial bit moved in clock high half");
  a_clock_idle_out: assert property (
    !o_sclk_oe_n && !fx |-> !sx)
    else $error("master clock toggles outside frame");
  a_frame_sixteen: assert property (
    $fell(fx) |-> bits == 6'h10)
    else $error("master frame not 16 bits");
  a_rac_busy_late: assert property (
    $fell(o_busy) && m_rac |-> bits == 6'h10 && !fx)
    else $error("busy fell before last bit");
  a_frame_in_busy: assert property (
    $rose(fx) |-> o_busy)
    else $error("master frame outside busy");
  a_overrun_pulse: assert property (
    o_read_overrun_flag |-> i_serial_parallel_select && i_clock_source_select && !o_busy
      ##1 !o_read_overrun_flag)
    else $error("overrun pulse wrong");
  a_slave_no_clock: assert property (
    i_clock_source_select && $past(i_clock_source_select, 8) |-> o_sclk_oe_n && o_frame_valid_oe_n)
    else $error("master clock driven in slave mode");
endmodule

bind sarr_readout sarr_readout_assertions #(.CONV_CYC(CONV_CYC)) sarr_readout_assertions_inst (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_serial_parallel_select(i_serial_parallel_select),
  .i_clock_source_select(i_clock_source_select), .i_clock_invert(i_clock_invert),
  .i_read_mode_chain_input(i_read_mode_chain_input), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
  .o_busy(o_busy), .o_data_oe_n(o_data_oe_n), .o_serial_result_out(o_serial_result_out),
  .o_serial_oe_n(o_serial_oe_n), .o_sclk_out(o_sclk_out), .o_sclk_oe_n(o_sclk_oe_n),
  .o_frame_valid(o_frame_valid), .o_frame_valid_oe_n(o_frame_valid_oe_n),
  .o_read_overrun_flag(o_read_overrun_flag));

// >>> dv/sarr_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Host model: reads master frames, clocks slave frames
// ----------------------------------------------------------------------
module sarr_host_model (
  // System clock and fixed mode level
  input wire logic i_clk_sys,
  input wire logic i_mode,
  // Link pins from the converter
  input wire logic i_sdo,
  input wire logic i_sclk,
  input wire logic i_sclk_oe_n,
  input wire logic i_fv,
  input wire logic i_inv,
  // Link pins to the converter, words read
  output logic o_sclk_link = 1'b0,
  output logic o_chain,
  output logic [7:0] o_nw = 8'h00,
  output logic [15:0] o_word = 16'h0000
);
  logic [15:0] shm = 16'h0000;
  logic [15:0] shs = 16'h0000;
  logic [15:0] upq = 16'h0000;
  int nm = 0;
  int ns = 0;
  logic sq = 1'b0;
  logic fr = 1'b0;
  // Upstream chain bit in a frame, a fixed level outside it
  assign o_chain = fr ? upq[15] : i_mode;
  // Master frames: a bit at each rise of the corrected clock
  always @(posedge i_clk_sys) begin
    if (i_sclk_oe_n || !(i_fv ^ i_inv)) nm = 0;
    else if ((i_sclk ^ i_inv) && !sq) begin
      shm = {shm[14:0], i_sdo};
      nm++;
      if (nm == 16) begin
        o_word = shm;
        o_nw++;
      end
    end
    sq = i_sclk ^ i_inv;
  end
  // Slave frame: gated clock idling low, still between frames
  task automatic frame(input int nb, input logic [15:0] up);
    int i;
    ns = 0;
    upq = up;
    fr = 1'b1;
    for (i = 0; i < nb; i++) begin
      #32;
      o_sclk_link = 1'b1;
      shs = {shs[14:0], i_sdo};
      ns++;
      if (ns == 16) begin
        o_word = shs;
        o_nw++;
        ns = 0;
      end
      #32;
      o_sclk_link = 1'b0;
      upq = {upq[14:0], 1'b0};
    end
    #32;
    fr = 1'b0;
  endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Self-checking bench of the result readout
// ----------------------------------------------------------------------
module tb_top;
  localparam int CONV = 120;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] res = 16'h0000;
  logic cnv_n = 1'b1;
  logic pd = 1'b0;
  logic ser = 1'b0;
  logic swap = 1'b0;
  logic src = 1'b0;
  logic inv = 1'b0;
  logic rdm = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic [15:0] cur = 16'h0000;
  logic [15:0] prv = 16'h0000;
  logic [15:0] q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int ov_cnt = 0;
  wire sclk, chain, busy, d_oe_n, sdo, s_oe_n, msclk, m_oe_n, fv, fv_oe_n, ovr;
  wire [15:0] data;
  wire [15:0] word;
  wire [7:0] nw;

  sarr_readout #(.CONV_CYC(CONV)) sarr_readout_inst (
    .i_clk_sys(clk), .i_rst(rst), .i_sclk_link(sclk), .i_conv_result(res),
    .i_convert_start_n(cnv_n), .i_power_down(pd), .o_busy(busy),
    .i_serial_parallel_select(ser), .i_byte_lane_exchange(swap),
    .i_clock_source_select(src), .i_clock_invert(inv), .i_read_mode_chain_input(chain),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .o_data(data), .o_data_oe_n(d_oe_n),
    .o_serial_result_out(sdo), .o_serial_oe_n(s_oe_n), .o_sclk_out(msclk),
    .o_sclk_oe_n(m_oe_n), .o_frame_valid(fv), .o_frame_valid_oe_n(fv_oe_n),
    .o_read_overrun_flag(ovr));

  sarr_host_model sarr_host_model_inst (
    .i_clk_sys(clk), .i_mode(rdm), .i_sdo(sdo), .i_sclk(msclk), .i_sclk_oe_n(m_oe_n),
    .i_fv(fv), .i_inv(inv), .o_sclk_link(sclk), .o_chain(chain), .o_nw(nw), .o_word(word));

  always #12.5 clk = ~clk;

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Bounded wait; a hang ends the run at once
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 600 && busy !== lvl; i++) @(negedge clk);
    if (busy !== lvl) begin
      check("busy", {15'h0000, busy}, {15'h0000, lvl});
      end_sim();
    end
  endtask

  task automatic start(input logic [15:0] v);
    @(posedge clk);
    res <= v;
    cnv_n <= 1'b0;
    wait_busy(1'b1);
    @(posedge clk);
    cnv_n <= 1'b1;
  endtask

  task automatic finish();
    wait_busy(1'b0);
    prv = cur;
    cur = res;
    repeat (4) @(posedge clk);
  endtask

  task automatic sel(input logic lvl);
    @(posedge clk);
    cs_n <= lvl;
    rd_n <= lvl;
    repeat (8) @(posedge clk);
  endtask

  // Scoreboard: oldest note against each word that shows up
  task automatic take(input logic [15:0] seen);
    if (q.size() == 0) begin
      error_cnt++;
      $display("wrong value word expected none seen %h", seen);
    end
    else
      check("word", seen, q.pop_front());
  endtask

  always @(negedge d_oe_n) begin
    #2;
    take(data);
  end

  // The count settles to zero at time zero, which is no word
  always @(nw) if (nw != 8'h00) take(word);

  always @(posedge clk) begin
    if (ovr === 1'b1) ov_cnt++;
  end

  initial begin
    int unsigned v;
    int unsigned s;
    s = $urandom(12);
    // Link clock edges during and after reset clear the link side
    sarr_host_model_inst.frame(3, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    sarr_host_model_inst.frame(3, 16'h0000);
    repeat (8) @(posedge clk);
    // Parallel read after conversion in both lane orders; power-down mid-way
    for (int k = 0; k < 2; k++) begin
      v = $urandom;
      swap <= k[0];
      start(v[15:0]);
      pd <= 1'b1;
      finish();
      pd <= 1'b0;
      q.push_back(k[0] ? {cur[7:0], cur[15:8]} : cur);
      sel(1'b0);
      sel(1'b1);
    end
    // Parallel read early in the next conversion gives the held word
    v = $urandom;
    q.push_back({cur[7:0], cur[15:8]});
    start(v[15:0]);
    sel(1'b0);
    sel(1'b1);
    finish();
    // Master frames: both polarities, read after and read during
    ser <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      inv <= k[0];
      rdm <= k[1];
      sel(1'b0);
      q.push_back(k[1] ? cur : v[15:0]);
      start(v[15:0]);
      finish();
      repeat (40) @(posedge clk);
      sel(1'b1);
    end
    // Slave read after conversion, with an upstream word chained behind
    src <= 1'b1;
    inv <= 1'b0;
    rdm <= 1'b0;
    v = $urandom;
    start(v[15:0]);
    finish();
    sel(1'b0);
    q.push_back(cur);
    q.push_back(v[31:16]);
    sarr_host_model_inst.frame(32, v[31:16]);
    sel(1'b1);
    // Slave read during conversion: full frame, then a short one
    for (int k = 16; k > 0; k -= 8) begin
      v = $urandom;
      if (k == 16) q.push_back(cur);
      start(v[15:0]);
      sel(1'b0);
      sarr_host_model_inst.frame(k, 16'h0000);
      sel(1'b1);
      finish();
    end
    repeat (4) @(posedge clk);
    check("overrun pulses", ov_cnt[15:0], 16'h0001);
    check("words left", 16'(q.size()), 16'h0000);
    end_sim();
  end

  // Watchdog sized well past the expected run of a few thousand cycles
  initial begin
    #300us;
    error_cnt++;
    end_sim();
  end
endmodule
